// ==== src/fnl_pkg.sv ====
`default_nettype none
package fnl_pkg;
   localparam int unsigned FNL_XLEN = 32;
   localparam int unsigned FNL_RIDX = 5;
   // primary opcode shared by all four instructions
   localparam logic [5:0] FNL_PRIMARY_OP = 6'h1f;
   // extended opcodes (negate is 9 bits, the logical ones 10 bits)
   localparam logic [8:0] FNL_XO_NEGATE = 9'h068;
   localparam logic [9:0] FNL_XO_NOR = 10'h07c;
   localparam logic [9:0] FNL_XO_OR = 10'h1bc;
   localparam logic [9:0] FNL_XO_NAND = 10'h1dc;
   // field positions, lsb index of a 32-bit word where bit 0 is the lsb
   localparam int unsigned FNL_POS_PRIMARY = 26;
   localparam int unsigned FNL_POS_FIELD_A = 21;
   localparam int unsigned FNL_POS_FIELD_B = 16;
   localparam int unsigned FNL_POS_FIELD_C = 11;
   localparam int unsigned FNL_POS_OVF_EN = 10;
   localparam int unsigned FNL_POS_XO = 1;
   localparam int unsigned FNL_POS_RECORD = 0;
   // exception flag reset value
   localparam logic FNL_FLAG_RST = 1'b0;
   localparam logic [31:0] FNL_MOST_NEG = 32'h8000_0000;
   localparam logic [31:0] FNL_ZERO = 32'h0000_0000;
   localparam logic [4:0] FNL_REG_RST = 5'h00;

   typedef enum logic [2:0]
   {
      FNL_OP_NONE = 3'h0,
      FNL_OP_NEG = 3'h1,
      FNL_OP_NOR = 3'h3,
      FNL_OP_OR = 3'h2,
      FNL_OP_NAND = 3'h6
   } fnl_op_t;
endpackage : fnl_pkg
`default_nettype wire

// ==== src/fnl_dec_if.sv ====
`default_nettype none
// decoded instruction fields from the decoder to the datapath
interface fnl_dec_if;
   import fnl_pkg::*;
   fnl_op_t op;
   logic [4:0] target_reg_field;
   logic [4:0] first_reg_field;
   logic [4:0] second_source_reg_field;
   logic ovf_enable;
   logic record_bit;
   modport dec (output op, target_reg_field, first_reg_field, second_source_reg_field,
      ovf_enable, record_bit);
   modport exe (input op, target_reg_field, first_reg_field, second_source_reg_field,
      ovf_enable, record_bit);
endinterface : fnl_dec_if
`default_nettype wire

// ==== src/fnl_decode.sv ====
`default_nettype none
module fnl_decode
   import fnl_pkg::*;
(
   // raw instruction word
   input wire logic [31:0] i_insn,
   input wire logic i_valid,
   // decoded fields
   fnl_dec_if.dec o_dec
);
   logic [5:0] primary;
   logic [8:0] xo9;
   logic [9:0] xo10;
   logic is_x_form;

   // opcode fields; negate uses only nine bits because bit 21 is the overflow enable
   assign primary = i_insn[FNL_POS_PRIMARY +: 6];
   assign xo9 = i_insn[FNL_POS_XO +: 9];
   assign xo10 = i_insn[FNL_POS_XO +: 10];
   assign is_x_form = i_valid && (primary == FNL_PRIMARY_OP);

   // operation select, anything else is not ours and does nothing
   assign o_dec.op = !is_x_form ? FNL_OP_NONE :
      (xo9 == FNL_XO_NEGATE) ? FNL_OP_NEG :
      (xo10 == FNL_XO_NOR) ? FNL_OP_NOR :
      (xo10 == FNL_XO_OR) ? FNL_OP_OR :
      (xo10 == FNL_XO_NAND) ? FNL_OP_NAND : FNL_OP_NONE;

   // register number fields
   assign o_dec.target_reg_field = i_insn[FNL_POS_FIELD_A +: 5];
   assign o_dec.first_reg_field = i_insn[FNL_POS_FIELD_B +: 5];
   assign o_dec.second_source_reg_field = i_insn[FNL_POS_FIELD_C +: 5];
   assign o_dec.ovf_enable = i_insn[FNL_POS_OVF_EN];
   assign o_dec.record_bit = i_insn[FNL_POS_RECORD];
endmodule : fnl_decode
`default_nettype wire

// ==== src/fnl_unit.sv ====
`default_nettype none
module fnl_unit
   import fnl_pkg::*;
#(
   parameter int unsigned XLEN = FNL_XLEN
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // instruction from decode stage
   input wire logic i_valid,
   input wire logic [31:0] i_insn,
   // general register read ports (source data for the decoded numbers)
   input wire logic [XLEN-1:0] i_src_a_data,
   input wire logic [XLEN-1:0] i_src_b_data,
   output logic [4:0] o_src_a_num,
   output logic [4:0] o_src_b_num,
   // write back
   output logic o_wr_en,
   output logic [4:0] o_wr_num,
   output logic [XLEN-1:0] o_wr_data,
   // exception flags
   output logic o_overflow_flag,
   output logic o_summary_overflow,
   output logic o_carry_flag,
   // condition field zero
   output logic o_cr0_wr,
   output logic o_less_than_flag,
   output logic o_greater_than_flag,
   output logic o_equal_zero_flag,
   output logic o_cr0_summary
);
   fnl_dec_if dec_bus ();

   fnl_decode u_decode
   (
      .i_insn (i_insn),
      .i_valid (i_valid),
      .o_dec (dec_bus)
   );

   logic [4:0] src_a_num_r;
   logic [4:0] src_b_num_r;
   logic [4:0] wr_num_r;
   logic [4:0] wr_num_nxt;
   fnl_op_t op_r;
   logic ovf_en_r;
   logic record_r;
   logic [XLEN-1:0] result;
   logic [XLEN-1:0] neg_val;
   logic is_neg;
   logic is_logic;
   logic neg_ovf;
   logic upd_xer;
   logic ov_nxt;
   logic so_nxt;
   logic wr_en_r;
   logic [XLEN-1:0] wr_data_r;
   logic ov_r;
   logic so_r;
   logic ca_r;
   logic cr0_wr_r;
   logic lt_r;
   logic gt_r;
   logic eq_r;
   logic cr0_so_r;
   logic [4:0] wb_num_r;
   logic exec_any;
   logic res_sign;
   logic res_zero;

   // zero test of a result word, kept apart so both flag terms share it
   function automatic logic fnl_is_zero(input logic [XLEN-1:0] value);
      return (value == FNL_ZERO[XLEN-1:0]);
   endfunction : fnl_is_zero

   // write number: negate writes the target field; logicals write the register in the first field
   assign wr_num_nxt = (dec_bus.op == FNL_OP_NEG) ? dec_bus.target_reg_field :
      dec_bus.first_reg_field;

   // stage 1: latch operation and issue register numbers (data arrives next cycle)
   // number fields latch every cycle; only op_r says whether they matter
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         op_r <= FNL_OP_NONE;
         src_a_num_r <= FNL_REG_RST;
         src_b_num_r <= FNL_REG_RST;
         wr_num_r <= FNL_REG_RST;
         ovf_en_r <= 1'b0;
         record_r <= 1'b0;
      end
      else
      begin
         op_r <= dec_bus.op;
         // negate source sits in 11-15, logical first source in 6-10
         src_a_num_r <= (dec_bus.op == FNL_OP_NEG) ? dec_bus.first_reg_field :
            dec_bus.target_reg_field;
         src_b_num_r <= dec_bus.second_source_reg_field;
         wr_num_r <= wr_num_nxt;
         ovf_en_r <= dec_bus.ovf_enable && (dec_bus.op == FNL_OP_NEG);
         record_r <= dec_bus.record_bit;
      end
   end

   // result mux; wraparound of the add leaves the most negative value unchanged
   assign neg_val = ~i_src_a_data + {{(XLEN-1){1'b0}}, 1'b1};
   assign is_neg = (op_r == FNL_OP_NEG);
   assign is_logic = (op_r == FNL_OP_OR) || (op_r == FNL_OP_NOR) || (op_r == FNL_OP_NAND);
   assign result = is_neg ? neg_val :
      (op_r == FNL_OP_NOR) ? ~(i_src_a_data | i_src_b_data) :
      (op_r == FNL_OP_OR) ? (i_src_a_data | i_src_b_data) :
      ~(i_src_a_data & i_src_b_data);

   // overflow only for the one input that has no positive counterpart
   assign neg_ovf = (i_src_a_data == FNL_MOST_NEG[XLEN-1:0]);
   // logical ops never touch the exception flags
   assign upd_xer = is_neg && ovf_en_r;
   assign ov_nxt = upd_xer ? neg_ovf : ov_r;
   assign so_nxt = so_r | (upd_xer & neg_ovf);

   // shared terms for write back and the condition field
   assign exec_any = is_neg || is_logic;
   assign res_sign = result[XLEN-1];
   assign res_zero = fnl_is_zero(result);

   // stage 2: write back and flags
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wr_en_r <= 1'b0;
         wr_data_r <= {XLEN{1'b0}};
         ov_r <= FNL_FLAG_RST;
         so_r <= FNL_FLAG_RST;
         cr0_wr_r <= 1'b0;
         lt_r <= 1'b0;
         gt_r <= 1'b0;
         eq_r <= 1'b0;
         cr0_so_r <= 1'b0;
      end
      else
      begin
         wr_en_r <= exec_any;
         if (exec_any)
         begin
            wr_data_r <= result;
         end
         ov_r <= ov_nxt;
         so_r <= so_nxt;
         // field only written when the record bit is set
         cr0_wr_r <= exec_any && record_r;
         if (exec_any && record_r)
         begin
            lt_r <= res_sign;
            gt_r <= !res_sign && !res_zero;
            eq_r <= res_zero;
            cr0_so_r <= so_nxt;
         end
      end
   end

   // carry is owned by other instructions; this unit only holds it at reset value
   // kept as a register so the output still comes from a flip-flop
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ca_r <= FNL_FLAG_RST;
      end
      else
      begin
         ca_r <= ca_r;
      end
   end

   // outputs straight from flip-flops
   assign o_src_a_num = src_a_num_r;
   assign o_src_b_num = src_b_num_r;
   assign o_wr_en = wr_en_r;
   assign o_wr_num = wb_num_r;
   assign o_wr_data = wr_data_r;
   assign o_overflow_flag = ov_r;
   assign o_summary_overflow = so_r;
   assign o_carry_flag = ca_r;
   assign o_cr0_wr = cr0_wr_r;
   assign o_less_than_flag = lt_r;
   assign o_greater_than_flag = gt_r;
   assign o_equal_zero_flag = eq_r;
   assign o_cr0_summary = cr0_so_r;

   // delay write number to line up with the result stage
   // not held on idle cycles: only o_wr_en says whether it means anything
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wb_num_r <= FNL_REG_RST;
      end
      else
      begin
         wb_num_r <= wr_num_r;
      end
   end
endmodule : fnl_unit
`default_nettype wire

// ==== bench/fnl_regfile.sv ====
`default_nettype none
// general register file beside the unit
module fnl_regfile
(
   // read numbers
   input wire logic [4:0] i_num_a,
   input wire logic [4:0] i_num_b,
   // read data
   output logic [31:0] o_data_a,
   output logic [31:0] o_data_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [32];
   // no read latency: the unit samples one cycle after showing the number
   assign o_data_a = mem[i_num_a];
   assign o_data_b = mem[i_num_b];
endmodule : fnl_regfile
`default_nettype wire

// ==== bench/fnl_unit_props.sv ====
`default_nettype none
module fnl_unit_props
   import fnl_pkg::*;
#(
   parameter int unsigned XLEN = FNL_XLEN
)
(
   // clock, reset, request
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_valid,
   input wire logic [31:0] i_insn,
   input wire logic [XLEN-1:0] i_src_a_data,
   input wire logic [XLEN-1:0] i_src_b_data,
   // unit outputs
   input wire logic [4:0] o_src_a_num,
   input wire logic [4:0] o_src_b_num,
   input wire logic o_wr_en,
   input wire logic [4:0] o_wr_num,
   input wire logic [XLEN-1:0] o_wr_data,
   input wire logic o_overflow_flag,
   input wire logic o_summary_overflow,
   input wire logic o_carry_flag,
   input wire logic o_cr0_wr,
   input wire logic o_less_than_flag,
   input wire logic o_greater_than_flag,
   input wire logic o_equal_zero_flag,
   input wire logic o_cr0_summary
);
   timeunit 1ns;
   timeprecision 1ns;
   // own decode, so a slip shared with the unit cannot hide
   wire logic op_ok = i_valid && i_insn[31:26] == FNL_PRIMARY_OP;
   wire logic is_neg = op_ok && i_insn[9:1] == FNL_XO_NEGATE;
   wire logic is_or = op_ok && i_insn[10:1] == FNL_XO_OR;
   wire logic is_nor = op_ok && i_insn[10:1] == FNL_XO_NOR;
   wire logic is_nand = op_ok && i_insn[10:1] == FNL_XO_NAND;
   wire logic is_lg = is_or || is_nor || is_nand;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   a_neg_result: assert property (is_neg |-> ##2 o_wr_num == $past(i_insn[25:21], 2)
      && o_wr_data == ~$past(i_src_a_data) + 1) else $error("negate result wrong");
   a_lg_sources: assert property (is_lg |=> o_src_a_num == $past(i_insn[25:21])
      && o_src_b_num == $past(i_insn[15:11])) else $error("source numbers wrong");
   a_or_result: assert property (is_or |-> ##2 o_wr_num == $past(i_insn[20:16], 2)
      && o_wr_data == ($past(i_src_a_data) | $past(i_src_b_data))) else $error("or wrong");
   a_nor_result: assert property (is_nor |-> ##2 o_wr_num == $past(i_insn[20:16], 2)
      && o_wr_data == ~($past(i_src_a_data) | $past(i_src_b_data))) else $error("nor wrong");
   a_nand_result: assert property (is_nand |-> ##2
      o_wr_data == ~($past(i_src_a_data) & $past(i_src_b_data))) else $error("nand wrong");
   a_lg_flags: assert property (is_lg |-> ##2 $stable(o_overflow_flag)
      && $stable(o_summary_overflow)) else $error("logical op changed flags");
   a_ovf_most: assert property (is_neg && i_insn[10] |-> ##2
      o_overflow_flag == ($past(i_src_a_data) == FNL_MOST_NEG)) else $error("overflow wrong");
   a_ovf_kept: assert property (!(is_neg && i_insn[10]) |-> ##2
      $stable(o_overflow_flag)) else $error("overflow changed");
   a_summary_sticky: assert property ($fell(o_summary_overflow) |-> $past(i_rst))
      else $error("summary cleared");
   a_carry_zero: assert property (o_carry_flag == 1'b0) else $error("carry changed");
   a_cr0_record: assert property (is_neg || is_lg |-> ##2 o_wr_en
      && o_cr0_wr == $past(i_insn[0], 2)) else $error("record wrong");
   a_cr0_value: assert property (o_cr0_wr |-> o_less_than_flag == o_wr_data[31]
      && o_equal_zero_flag == (o_wr_data == '0) && o_cr0_summary == o_summary_overflow
      && o_greater_than_flag == !(o_wr_data[31] || o_wr_data == '0)) else $error("cr0 wrong");
endmodule : fnl_unit_props
bind fnl_unit fnl_unit_props #(.XLEN(XLEN)) u_props (.i_mclk, .i_rst, .i_valid, .i_insn,
   .i_src_a_data, .i_src_b_data, .o_src_a_num, .o_src_b_num, .o_wr_en, .o_wr_num, .o_wr_data,
   .o_overflow_flag, .o_summary_overflow, .o_carry_flag, .o_cr0_wr, .o_less_than_flag,
   .o_greater_than_flag, .o_equal_zero_flag, .o_cr0_summary);
`default_nettype wire

// ==== bench/testbench.sv ====
`default_nettype none
module testbench
   import fnl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 1'b0, i_rst = 1'b1, i_valid = 1'b0;
   logic [31:0] i_insn = '0, src_a, src_b, wr_data;
   logic [4:0] na, nb, wr_num;
   logic wr_en, ovf, so, ca, cr_wr, lt, gt, eq, cr_so;
   int mismatches = 0, tests_run = 0, cycles = 0;
   logic [9:0] xo [3] = '{FNL_XO_OR, FNL_XO_NOR, FNL_XO_NAND};
   logic [31:0] lg_exp [3] = '{32'hf89e_789b, 32'h0761_8764, 32'hcfff_cfff};
   logic [8:0] lg_fl [3] = '{9'h1a9, 9'h1a5, 9'h1a9};
   fnl_unit dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(i_valid), .i_insn(i_insn),
      .i_src_a_data(src_a), .i_src_b_data(src_b), .o_src_a_num(na), .o_src_b_num(nb),
      .o_wr_en(wr_en), .o_wr_num(wr_num), .o_wr_data(wr_data), .o_overflow_flag(ovf),
      .o_summary_overflow(so), .o_carry_flag(ca), .o_cr0_wr(cr_wr), .o_less_than_flag(lt),
      .o_greater_than_flag(gt), .o_equal_zero_flag(eq), .o_cr0_summary(cr_so));
   fnl_regfile rf (.i_num_a(na), .i_num_b(nb), .o_data_a(src_a), .o_data_b(src_b));
   function automatic logic [31:0] neg_w(logic [4:0] rt, ra, logic oe, rc);
      return {FNL_PRIMARY_OP, rt, ra, 5'h00, oe, FNL_XO_NEGATE, rc};
   endfunction : neg_w
   function automatic logic [31:0] lg_w(logic [9:0] x, logic [4:0] rs, ra, rb, logic rc);
      return {FNL_PRIMARY_OP, rs, ra, rb, x, rc};
   endfunction : lg_w
   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one request, then wait into the cycle where the result stands
   task automatic run(input logic [31:0] insn);
      @(posedge i_mclk);
      i_valid <= 1'b1;
      i_insn <= insn;
      @(posedge i_mclk);
      i_valid <= 1'b0;
      @(posedge i_mclk);
      #1;
   endtask : run
   // flags packed as wr_en, cr_wr, ovf, so, ca, lt, gt, eq, cr_so
   task automatic res(input logic [4:0] n, input logic [31:0] d, input logic [8:0] f);
      check("wr_num", wr_num, n);
      check("wr_data", wr_data, d);
      check("flags", {wr_en, cr_wr, ovf, so, ca, lt, gt, eq, cr_so}, f);
   endtask : res
   task automatic t_negate;
      rf.mem[0] = '0;
      rf.mem[1] = 32'h0000_0001;
      rf.mem[4] = 32'h9000_3000;
      rf.mem[5] = 32'h8000_0000;
      rf.mem[7] = 32'h789a_789b;
      run(neg_w(6, 4, 1'b0, 1'b0));
      res(6, 32'h6fff_d000, 9'h100);
      run(neg_w(8, 7, 1'b0, 1'b1));
      res(8, 32'h8765_8765, 9'h188);
      run(neg_w(6, 5, 1'b1, 1'b1));
      res(6, 32'h8000_0000, 9'h1e9);
      run(neg_w(6, 5, 1'b0, 1'b0));
      res(6, 32'h8000_0000, 9'h169);
      run(neg_w(9, 1, 1'b1, 1'b0));
      res(9, 32'hffff_ffff, 9'h129);
      run(neg_w(3, 0, 1'b0, 1'b1));
      res(3, 32'h0000_0000, 9'h1a3);
   endtask : t_negate
   // or, nor, nand with record, then a plain or and an unknown opcode
   task automatic t_logic;
      rf.mem[4] = 32'hb004_3000;
      for (int k = 0; k < 3; k++)
      begin
         run(lg_w(xo[k], 4, 6, 7, 1'b1));
         res(6, lg_exp[k], lg_fl[k]);
      end
      run(lg_w(FNL_XO_OR, 0, 9, 0, 1'b0));
      res(9, 32'h0000_0000, 9'h129);
      // number field still latches; the low write strobe is what refuses it
      run(lg_w(10'h19c, 4, 6, 7, 1'b1));
      res(6, 32'h0000_0000, 9'h029);
   endtask : t_logic
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // free-running clock
   initial
   begin
      forever #5 i_mclk = ~i_mclk;
   end
   // hang guard, far above the 40 cycles needed
   always @(posedge i_mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         mismatches++;
         complete_run;
      end
   end
   // main sequence
   initial
   begin
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      #1;
      res(0, 32'h0000_0000, 9'h000);
      t_negate;
      t_logic;
      complete_run;
   end
endmodule : testbench
`default_nettype wire
